// *** hdl/dsz_exec.sv ***
// Summary of operation
// RULE_01: Opcode 001011da decrements, flags left alone.
// RULE_02: Destination bit picks working or file register.
// RULE_03: Zero result discards prefetched word, runs nop.
// RULE_04: Access bit picks access bank or bank.
// RULE_05: Extended set, access bank, f<=5Fh: indexed.
// RULE_06: One word; one, two or three cycles.
// RULE_07: Opcode 000001da decrements and updates five flags.
// RULE_08: Phases: decode, read, decrement, write destination.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module dsz_exec
   import dsz_pkg::*;
#(
   parameter int unsigned BANK_W = 4
)(
   input  wire logic                        clk_in,
   input  wire logic                        arst_n_in,
   // AXI4-Lite register slave
   input  wire logic [dsz_pkg::AXI_AW-1:0]  s_axil_awaddr_in,
   input  wire logic                        s_axil_awvalid_in,
   output logic                             s_axil_awready_out,
   input  wire logic [31:0]                 s_axil_wdata_in,
   input  wire logic [3:0]                  s_axil_wstrb_in,
   input  wire logic                        s_axil_wvalid_in,
   output logic                             s_axil_wready_out,
   output logic [1:0]                       s_axil_bresp_out,
   output logic                             s_axil_bvalid_out,
   input  wire logic                        s_axil_bready_in,
   input  wire logic [dsz_pkg::AXI_AW-1:0]  s_axil_araddr_in,
   input  wire logic                        s_axil_arvalid_in,
   output logic                             s_axil_arready_out,
   output logic [31:0]                      s_axil_rdata_out,
   output logic [1:0]                       s_axil_rresp_out,
   output logic                             s_axil_rvalid_out,
   input  wire logic                        s_axil_rready_in,
   // Instruction stream
   input  wire logic [15:0]                 instr_word_in,
   input  wire logic                        next_two_word_in,
   output logic                             instr_take_out,
   output logic                             flush_out,
   output logic [1:0]                       phase_out,
   // Data memory port
   output logic [dsz_pkg::DATA_ADDR_W-1:0]  fr_addr_out,
   output logic                             fr_rd_out,
   input  wire logic [7:0]                  fr_rdata_in,
   output logic                             fr_wr_out,
   output logic [7:0]                       fr_wdata_out
);
   typedef struct packed {
      // Execution pipeline
      dsz_phase_t             phase;
      dsz_kind_t              kind;
      logic                   dest;
      logic [DATA_ADDR_W-1:0] addr;
      logic [7:0]             opnd;
      logic [7:0]             res;
      logic [4:0]             flags;
      logic [1:0]             flush_cnt;
      logic                   flushing;
      logic                   take;
      logic                   rd;
      logic                   wr;
      logic [7:0]             wdata;
      // Software-visible registers
      logic                   ext_en;
      logic [BANK_W-1:0]      bank;
      logic [7:0]             wreg;
      logic [4:0]             status;
      logic [DATA_ADDR_W-1:0] index_base;
      logic [7:0]             skip_cnt;
   } dsz_exec_st_t;

   dsz_exec_st_t           q;
   dsz_exec_st_t           d;
   logic [1:0]             rst_sync_q;
   logic                   rst_n;
   logic [DATA_ADDR_W-1:0] gen_addr;
   logic [5:0]             opc;
   dsz_kind_t              kind_dec;
   logic [7:0]             diff;
   logic [4:0]             flags_calc;

   dsz_reg_if regs ();

   // Asynchronous assert, synchronous release
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Register bus, answers reads one cycle and writes two cycles after the request is taken
   dsz_axil_slave u_axil (
      .clk_in      (clk_in),
      .rst_n_in    (rst_n),
      .awaddr_in   (s_axil_awaddr_in),
      .awvalid_in  (s_axil_awvalid_in),
      .awready_out (s_axil_awready_out),
      .wdata_in    (s_axil_wdata_in),
      .wstrb_in    (s_axil_wstrb_in),
      .wvalid_in   (s_axil_wvalid_in),
      .wready_out  (s_axil_wready_out),
      .bresp_out   (s_axil_bresp_out),
      .bvalid_out  (s_axil_bvalid_out),
      .bready_in   (s_axil_bready_in),
      .araddr_in   (s_axil_araddr_in),
      .arvalid_in  (s_axil_arvalid_in),
      .arready_out (s_axil_arready_out),
      .rdata_out   (s_axil_rdata_out),
      .rresp_out   (s_axil_rresp_out),
      .rvalid_out  (s_axil_rvalid_out),
      .rready_in   (s_axil_rready_in),
      .regs        (regs)
   );

   dsz_addr_gen #(
      .BANK_W (BANK_W)
   ) u_addr (
      .f_in          (instr_word_in[7:0]),
      .acc_in        (instr_word_in[ACC_BIT]),
      .ext_en_in     (q.ext_en),
      .bank_in       (q.bank),
      .index_base_in (q.index_base),
      .addr_out      (gen_addr)
   );

   // Decoded live; only the edge ending Q1 uses it
   assign opc = instr_word_in[OPC_MSB:OPC_LSB];

   always_comb
   begin
      if (opc == OPC_DEC_SKIP)
      begin
         kind_dec = DSZ_SKIP; // RULE_01
      end
      else if (opc == OPC_DEC_FILE)
      begin
         kind_dec = DSZ_DEC; // RULE_07
      end
      else
      begin
         kind_dec = DSZ_NONE;
      end
   end

   // Decrement and the flags it would produce
   // C and DC are inverted borrows, as for any subtraction
   assign diff              = q.opnd - 8'h01;
   assign flags_calc[ST_C]  = (q.opnd != 8'h00); // RULE_07
   assign flags_calc[ST_DC] = (q.opnd[3:0] != 4'h0);
   assign flags_calc[ST_Z]  = (diff == 8'h00);
   assign flags_calc[ST_OV] = (q.opnd == 8'h80);
   assign flags_calc[ST_N]  = diff[7];

   // Register read view
   // Unused bits and slots read as zero
   always_comb
   begin
      regs.rd_data = 32'h0000_0000;
      case (regs.rd_idx)
         IDX_W'(OFS_CTRL >> 2):   regs.rd_data[CTRL_EXT_BIT] = q.ext_en;
         IDX_W'(OFS_BANK >> 2):   regs.rd_data[BANK_W-1:0] = q.bank;
         IDX_W'(OFS_WREG >> 2):   regs.rd_data[7:0] = q.wreg;
         IDX_W'(OFS_STATUS >> 2): regs.rd_data[4:0] = q.status;
         IDX_W'(OFS_INDEX >> 2):  regs.rd_data[DATA_ADDR_W-1:0] = q.index_base;
         IDX_W'(OFS_EXEC >> 2):
         begin
            regs.rd_data[EXEC_FLUSH_BIT] = q.flushing;
            regs.rd_data[EXEC_CNT_LSB +: 8] = q.skip_cnt;
         end
         default:                 regs.rd_data = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      d      = q;
      d.take = 1'b0;
      d.rd   = 1'b0;
      d.wr   = 1'b0;
      // Software writes; the core's own Q4 update below takes precedence
      if (regs.wr_stb && regs.wr_be[0])
      begin
         case (regs.wr_idx)
            IDX_W'(OFS_CTRL >> 2):   d.ext_en = regs.wr_data[CTRL_EXT_BIT];
            IDX_W'(OFS_BANK >> 2):   d.bank = regs.wr_data[BANK_W-1:0];
            IDX_W'(OFS_WREG >> 2):   d.wreg = regs.wr_data[7:0];
            IDX_W'(OFS_STATUS >> 2): d.status = regs.wr_data[4:0];
            IDX_W'(OFS_INDEX >> 2):  d.index_base = regs.wr_data[DATA_ADDR_W-1:0];
            default:                 d.status = d.status;
         endcase
      end
      // One instruction cycle is four clocks, Q1 to Q4
      case (q.phase)
         DSZ_Q1:
         begin
            d.phase = DSZ_Q2;
            d.take  = 1'b1;
            if (q.flush_cnt != 2'h0)
            begin
               // Prefetched word dropped, whole cycle is a nop
               d.flushing  = 1'b1; // RULE_03
               d.flush_cnt = q.flush_cnt - 2'h1; // RULE_06
               d.kind      = DSZ_NONE;
            end
            else
            begin
               d.flushing = 1'b0;
               d.kind     = kind_dec; // RULE_08
               d.dest     = instr_word_in[DEST_BIT];
               // Operand address frozen for the rest of the cycle
               d.addr     = gen_addr; // RULE_04
               d.rd       = (kind_dec != DSZ_NONE);
            end
         end
         DSZ_Q2:
         begin
            d.phase = DSZ_Q3;
            if (q.kind != DSZ_NONE)
            begin
               // Memory answers within the read-strobe cycle
               d.opnd = fr_rdata_in; // RULE_08
            end
         end
         DSZ_Q3:
         begin
            d.phase = DSZ_Q4;
            if (q.kind != DSZ_NONE)
            begin
               // Flags formed for both forms, kept by the plain one only
               d.res   = diff; // RULE_08
               d.flags = flags_calc;
               if (q.dest)
               begin
                  d.wr    = 1'b1; // RULE_02
                  d.wdata = diff;
               end
            end
         end
         DSZ_Q4:
         begin
            d.phase = DSZ_Q1;
            if (q.kind != DSZ_NONE)
            begin
               if (!q.dest)
               begin
                  d.wreg = q.res; // RULE_02
               end
               if (q.kind == DSZ_DEC)
               begin
                  d.status = q.flags; // RULE_07
               end
               if ((q.kind == DSZ_SKIP) && (q.res == 8'h00))
               begin
                  // Nop length follows the width of the prefetched word
                  d.flush_cnt = next_two_word_in ? SKIP_CYC_2WORD : SKIP_CYC_1WORD; // RULE_06
                  d.skip_cnt  = q.skip_cnt + 8'h01; // RULE_03
               end
            end
         end
         default:
         begin
            d.phase = DSZ_Q1;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Start at Q1 with nothing pending
         q            <= '0;
         q.phase      <= DSZ_Q1;
         q.kind       <= DSZ_NONE;
         q.ext_en     <= RST_EXT;
         q.wreg       <= RST_WREG;
         q.status     <= RST_STATUS;
         q.index_base <= RST_INDEX;
      end
      else
      begin
         q <= d;
      end
   end

   // All instruction-side outputs come straight from state
   assign instr_take_out = q.take;
   assign flush_out      = q.flushing;
   assign phase_out      = q.phase;
   assign fr_addr_out    = q.addr;
   assign fr_rd_out      = q.rd;
   assign fr_wr_out      = q.wr;
   assign fr_wdata_out   = q.wdata;
endmodule : dsz_exec

// *** hdl/dsz_pkg.sv ***
package dsz_pkg;
   // Data memory address and instruction fields
   localparam int unsigned DATA_ADDR_W    = 12;
   localparam int unsigned OPC_MSB        = 15;
   localparam int unsigned OPC_LSB        = 10;
   localparam int unsigned DEST_BIT       = 9;
   localparam int unsigned ACC_BIT        = 8;
   localparam logic [5:0]  OPC_DEC_SKIP   = 6'h0b;
   localparam logic [5:0]  OPC_DEC_FILE   = 6'h01;
   localparam logic [7:0]  IDX_LIMIT      = 8'h5f;
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
   // Status flag positions
   localparam int unsigned ST_C           = 0;
   localparam int unsigned ST_DC          = 1;
   localparam int unsigned ST_Z           = 2;
   localparam int unsigned ST_OV          = 3;
   localparam int unsigned ST_N           = 4;
   // Register map, byte offsets
   localparam int unsigned AXI_AW         = 8;
   localparam int unsigned IDX_W          = 3;
   localparam logic [2:0]  REG_NUM        = 3'h6;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_BANK       = 8'h04;
   localparam logic [7:0]  OFS_WREG       = 8'h08;
   localparam logic [7:0]  OFS_STATUS     = 8'h0c;
   localparam logic [7:0]  OFS_INDEX      = 8'h10;
   localparam logic [7:0]  OFS_EXEC       = 8'h14;
   localparam int unsigned CTRL_EXT_BIT   = 0;
   localparam int unsigned EXEC_FLUSH_BIT = 0;
   localparam int unsigned EXEC_CNT_LSB   = 8;
   // Reset values
   localparam logic        RST_EXT        = 1'h0;
   localparam logic [7:0]  RST_WREG       = 8'h00;
   localparam logic [4:0]  RST_STATUS     = 5'h00;
   localparam logic [11:0] RST_INDEX      = 12'h000;
   // Nop cycles after a skip
   localparam logic [1:0]  SKIP_CYC_1WORD = 2'h1;
   localparam logic [1:0]  SKIP_CYC_2WORD = 2'h2;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [1:0] {DSZ_Q1, DSZ_Q2, DSZ_Q3, DSZ_Q4} dsz_phase_t;
   typedef enum logic [1:0] {DSZ_NONE, DSZ_DEC, DSZ_SKIP} dsz_kind_t;
endpackage : dsz_pkg

// *** hdl/dsz_reg_if.sv ***
`timescale 1ns/1ns
interface dsz_reg_if;
   import dsz_pkg::*;
   logic             wr_stb;
   logic [IDX_W-1:0] wr_idx;
   logic [31:0]      wr_data;
   logic [3:0]       wr_be;
   logic [IDX_W-1:0] rd_idx;
   logic [31:0]      rd_data;
   modport slave (output wr_stb, wr_idx, wr_data, wr_be, rd_idx, input rd_data);
   modport core  (input wr_stb, wr_idx, wr_data, wr_be, rd_idx, output rd_data);
endinterface : dsz_reg_if

// *** hdl/dsz_addr_gen.sv ***
`timescale 1ns/1ns
module dsz_addr_gen
   import dsz_pkg::*;
#(
   parameter int unsigned BANK_W = 4
)(
   input  wire logic [7:0]             f_in,
   input  wire logic                   acc_in,
   input  wire logic                   ext_en_in,
   input  wire logic [BANK_W-1:0]      bank_in,
   input  wire logic [DATA_ADDR_W-1:0] index_base_in,
   output logic      [DATA_ADDR_W-1:0] addr_out
);
   always_comb
   begin
      if (acc_in)
      begin
         addr_out = DATA_ADDR_W'({bank_in, f_in}); // RULE_04
      end
      else if (ext_en_in && (f_in <= IDX_LIMIT))
      begin
         addr_out = index_base_in + DATA_ADDR_W'(f_in); // RULE_05
      end
      else if (f_in < ACCESS_SPLIT)
      begin
         addr_out = DATA_ADDR_W'(f_in); // RULE_04
      end
      else
      begin
         addr_out = {ACCESS_HI_BANK, f_in}; // RULE_04
      end
   end
endmodule : dsz_addr_gen

// *** hdl/dsz_axil_slave.sv ***
`timescale 1ns/1ns
module dsz_axil_slave
   import dsz_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [AXI_AW-1:0] awaddr_in,
   input  wire logic              awvalid_in,
   output logic                   awready_out,
   input  wire logic [31:0]       wdata_in,
   input  wire logic [3:0]        wstrb_in,
   input  wire logic              wvalid_in,
   output logic                   wready_out,
   output logic [1:0]             bresp_out,
   output logic                   bvalid_out,
   input  wire logic              bready_in,
   input  wire logic [AXI_AW-1:0] araddr_in,
   input  wire logic              arvalid_in,
   output logic                   arready_out,
   output logic [31:0]            rdata_out,
   output logic [1:0]             rresp_out,
   output logic                   rvalid_out,
   input  wire logic              rready_in,
   dsz_reg_if.slave               regs
);
   typedef struct packed {
      logic             aw_have;
      logic [IDX_W-1:0] aw_idx;
      logic             aw_ok;
      logic             w_have;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
   } dsz_axi_st_t;

   dsz_axi_st_t q;
   dsz_axi_st_t d;
   logic        rd_ok;
   logic        do_wr;

   function automatic logic mapped(input logic [AXI_AW-1:0] a);
      mapped = (a[AXI_AW-1:IDX_W+2] == '0) && (a[IDX_W+1:2] < REG_NUM);
   endfunction : mapped

   assign awready_out  = !q.aw_have && !q.bvalid;
   assign wready_out   = !q.w_have && !q.bvalid;
   assign arready_out  = !q.rvalid;
   assign bvalid_out   = q.bvalid;
   assign bresp_out    = q.bresp;
   assign rvalid_out   = q.rvalid;
   assign rdata_out    = q.rdata;
   assign rresp_out    = q.rresp;
   assign do_wr        = q.aw_have && q.w_have && !q.bvalid;
   assign rd_ok        = mapped(araddr_in);
   assign regs.rd_idx  = araddr_in[IDX_W+1:2];
   assign regs.wr_stb  = do_wr && q.aw_ok;
   assign regs.wr_idx  = q.aw_idx;
   assign regs.wr_data = q.wdata;
   assign regs.wr_be   = q.wstrb;

   always_comb
   begin
      d = q;
      if (awvalid_in && awready_out)
      begin
         d.aw_have = 1'b1;
         d.aw_idx  = awaddr_in[IDX_W+1:2];
         d.aw_ok   = mapped(awaddr_in);
      end
      if (wvalid_in && wready_out)
      begin
         d.w_have = 1'b1;
         d.wdata  = wdata_in;
         d.wstrb  = wstrb_in;
      end
      if (do_wr)
      begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = q.aw_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (q.bvalid && bready_in)
      begin
         d.bvalid = 1'b0;
      end
      if (arvalid_in && arready_out)
      begin
         d.rvalid = 1'b1;
         d.rdata  = rd_ok ? regs.rd_data : 32'h0000_0000;
         d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (q.rvalid && rready_in)
      begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end
endmodule : dsz_axil_slave

// *** verif/dsz_exec_checker.sv ***
`timescale 1ns/1ns
module dsz_exec_checker
(
   input wire logic                            clk_in,
   input wire logic                            arst_n_in,
   input wire logic                            instr_take_out,
   input wire logic                            flush_out,
   input wire logic [1:0]                      phase_out,
   input wire logic [dsz_pkg::DATA_ADDR_W-1:0] fr_addr_out,
   input wire logic                            fr_rd_out,
   input wire logic                            fr_wr_out
);
   import dsz_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   phase_seq_a: assert property (phase_out != 2'h0 |=> phase_out == $past(phase_out) + 2'h1)
      else $error("phase did not advance");
   rd_phase_a: assert property (fr_rd_out |-> phase_out == 2'h1)
      else $error("read strobe outside read phase");
   wr_phase_a: assert property (fr_wr_out |-> phase_out == 2'h3 && $past(fr_rd_out, 2)
      && fr_addr_out == $past(fr_addr_out, 2)) else $error("write without matching read");
   take_phase_a: assert property (instr_take_out |-> phase_out == 2'h1)
      else $error("take pulse outside second phase");
   flush_len_a: assert property ($rose(flush_out) |-> (phase_out == 2'h1) ##0 flush_out [*4])
      else $error("forced nop shorter than one cycle");
   flush_end_a: assert property ($fell(flush_out) |-> phase_out == 2'h1)
      else $error("forced nop ended mid cycle");
   flush_cause_a: assert property ($rose(flush_out) |-> $past(fr_rd_out, 4))
      else $error("forced nop without decrement");
   flush_quiet_a: assert property (flush_out |-> !fr_rd_out && !fr_wr_out)
      else $error("memory access during forced nop");
endmodule : dsz_exec_checker

bind dsz_exec dsz_exec_checker chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .instr_take_out(instr_take_out), .flush_out(flush_out), .phase_out(phase_out),
   .fr_addr_out(fr_addr_out), .fr_rd_out(fr_rd_out), .fr_wr_out(fr_wr_out));

// *** verif/test_decrement_skip_zero_exec.sv ***
`timescale 1ns/1ns
module test_decrement_skip_zero_exec;
   import dsz_pkg::*;
   logic        clk_in = 1'b0, arst_n_in = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_d;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, take, flush, fr_rd, fr_wr;
   logic [1:0]  bresp, rresp, phase, rd_r;
   logic [15:0] instr = 16'h0000;
   logic        two_word = 1'b0;
   logic [11:0] fr_addr;
   logic [7:0]  fr_rdata, fr_wdata;
   logic [7:0]  mem [0:4095];
   int          n_errors = 0, cmp_count = 0;

   always #4 clk_in = ~clk_in;
   assign fr_rdata = fr_rd ? mem[fr_addr] : ~mem[fr_addr];
   always @(posedge clk_in)
      if (fr_wr === 1'b1) mem[fr_addr] <= fr_wdata;

   dsz_exec dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .s_axil_awaddr_in(awaddr), .s_axil_awvalid_in(awvalid), .s_axil_awready_out(awready),
      .s_axil_wdata_in(wdata), .s_axil_wstrb_in(4'hf), .s_axil_wvalid_in(wvalid),
      .s_axil_wready_out(wready), .s_axil_bresp_out(bresp), .s_axil_bvalid_out(bvalid),
      .s_axil_bready_in(bready), .s_axil_araddr_in(araddr), .s_axil_arvalid_in(arvalid),
      .s_axil_arready_out(arready), .s_axil_rdata_out(rdata), .s_axil_rresp_out(rresp),
      .s_axil_rvalid_out(rvalid), .s_axil_rready_in(rready), .instr_word_in(instr),
      .next_two_word_in(two_word), .instr_take_out(take), .flush_out(flush),
      .phase_out(phase), .fr_addr_out(fr_addr), .fr_rd_out(fr_rd), .fr_rdata_in(fr_rdata),
      .fr_wr_out(fr_wr), .fr_wdata_out(fr_wdata));

   task test_done;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic       bp;
      logic [1:0] r;
      bp = 1'b1;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (bp)
      begin
         @(posedge clk_in);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         r = bresp;
         bp = (bvalid !== 1'b1);
      end
      bready <= 1'b0;
      check("bresp", {30'h0, r}, {30'h0, er});
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic bp;
      bp = 1'b1;
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (bp)
      begin
         @(posedge clk_in);
         if (arready === 1'b1) arvalid <= 1'b0;
         rd_d = rdata;
         rd_r = rresp;
         bp = (rvalid !== 1'b1);
      end
      rready <= 1'b0;
      check("rdata", rd_d, e);
      check("rresp", {30'h0, rd_r}, {30'h0, er});
   endtask : rd_chk

   // Runs one instruction, then watches it and the next two cycles
   task dec(input logic [15:0] w, input logic tw, input logic [11:0] ea, input logic [7:0] v);
      int          rd_n, wr_n, fl_n, tk_n;
      logic [11:0] ra;
      logic [7:0]  wd, res;
      logic        skip;
      rd_n = 0;
      wr_n = 0;
      fl_n = 0;
      tk_n = 0;
      ra = 12'h000;
      wd = 8'h00;
      res = v - 8'h01;
      skip = (w[OPC_MSB:OPC_LSB] == OPC_DEC_SKIP);
      mem[ea] = v;
      do @(negedge clk_in); while (phase !== 2'h3);
      @(posedge clk_in);
      instr <= w;
      two_word <= tw;
      @(posedge clk_in);
      instr <= 16'h0000;
      repeat (12)
      begin
         @(negedge clk_in);
         rd_n += (fr_rd === 1'b1);
         if (fr_rd === 1'b1) ra = fr_addr;
         wr_n += (fr_wr === 1'b1);
         if (fr_wr === 1'b1) wd = fr_wdata;
         fl_n += (flush === 1'b1);
         tk_n += (take === 1'b1);
      end
      check("read count", rd_n, 1);
      check("read address", {20'h0, ra}, {20'h0, ea});
      check("write count", wr_n, {31'h0, w[DEST_BIT]});
      if (w[DEST_BIT]) check("write data", {24'h0, wd}, {24'h0, res});
      check("nop clocks", fl_n, (skip && res == 8'h00) ? (tw ? 8 : 4) : 0);
      check("take count", tk_n, 3);
      if (!w[DEST_BIT]) rd_chk(OFS_WREG, {24'h0, res}, RESP_OKAY);
   endtask : dec

   initial
   begin
      #200000;
      n_errors++;
      test_done;
   end

   initial
   begin
      repeat (5) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h0, RESP_OKAY);
      rd_chk(8'h18, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'h1, RESP_SLVERR);
      wr(OFS_BANK, 32'h3, RESP_OKAY);
      dec({OPC_DEC_SKIP, 2'b11, 8'h05}, 1'b0, 12'h305, 8'h01);
      dec({OPC_DEC_SKIP, 2'b10, 8'h20}, 1'b1, 12'h020, 8'h01);
      dec({OPC_DEC_SKIP, 2'b00, 8'h80}, 1'b1, 12'hf80, 8'h05);
      rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
      rd_chk(OFS_EXEC, 32'h0200, RESP_OKAY);
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      wr(OFS_INDEX, 32'h100, RESP_OKAY);
      dec({OPC_DEC_SKIP, 2'b10, 8'h5f}, 1'b0, 12'h15f, 8'h03);
      dec({OPC_DEC_SKIP, 2'b10, 8'h60}, 1'b0, 12'hf60, 8'h03);
      dec({OPC_DEC_SKIP, 2'b11, 8'h5f}, 1'b0, 12'h35f, 8'h03);
      dec({OPC_DEC_FILE, 2'b01, 8'h30}, 1'b0, 12'h330, 8'h80);
      rd_chk(OFS_STATUS, 32'h09, RESP_OKAY);
      dec({OPC_DEC_FILE, 2'b11, 8'h31}, 1'b0, 12'h331, 8'h01);
      rd_chk(OFS_STATUS, 32'h07, RESP_OKAY);
      dec({OPC_DEC_FILE, 2'b01, 8'h32}, 1'b0, 12'h332, 8'h00);
      rd_chk(OFS_STATUS, 32'h10, RESP_OKAY);
      dec({OPC_DEC_SKIP, 2'b11, 8'h33}, 1'b0, 12'h333, 8'h01);
      rd_chk(OFS_STATUS, 32'h10, RESP_OKAY);
      test_done;
   end
endmodule : test_decrement_skip_zero_exec
